//--- logic/scc_clock_gen.sv
`timescale 1ns/10ps
`default_nettype none
module scc_clock_gen
  import scc_pkg::*;
#(
  parameter int PWR_STAB_CYC = cyclesUp(PWR_STAB_NS)
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic optHs8M,
  input wire logic optLsStoppable,
  input wire logic optWdtEnable,
  input wire logic supplyFastRise,
  input wire logic x1ClkPin,
  input wire logic stopReq,
  input wire logic wakeReq,
  output logic hsOscRun,
  output logic xtalRun,
  output logic lsOscRun,
  output logic pllRunOut,
  output logic ampHighGain,
  output logic cpuClkEn,
  output logic cpuRun,
  output logic wdtClkEn,
  output logic timerClkEn
);
  localparam int PLL_INT_CYC = cyclesUp(PLL_INT_WAIT_NS);
  localparam int PLL_STAB_CYC = cyclesUp(PLL_STAB_NS);
  localparam int HS_START_CYC = cyclesUp(HS_START_NS);
  localparam int HS_ACC_CYC = cyclesUp(HS_ACC_NS);
  localparam int LS_DIV = CLK_HZ / LS_HZ;

  scc_clk_if ck ();

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [5:0] syncA_reg;
  logic [5:0] syncB_reg;
  logic x1Last_reg;
  logic optsValid;
  logic hs8m;
  logic lsStoppable;
  logic wdtEn;
  logic fastRise;
  logic x1Rise;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA_reg <= 6'h00;
      syncB_reg <= 6'h00;
      x1Last_reg <= 1'b0;
    end else begin
      // top bit marks both stages as holding a real pin sample
      syncA_reg <= {1'b1, x1ClkPin, supplyFastRise, optWdtEnable, optLsStoppable, optHs8M};
      syncB_reg <= syncA_reg;
      x1Last_reg <= syncB_reg[4];
    end
  end

  assign optsValid = syncB_reg[5];
  assign hs8m = syncB_reg[0];
  assign lsStoppable = syncB_reg[1];
  assign wdtEn = syncB_reg[2];
  assign fastRise = syncB_reg[3];
  assign x1Rise = syncB_reg[4] & ~x1Last_reg;

  //////////////////////////////////////////////////////////////////////////
  // register state
  logic hsStop_reg;
  logic lsStop_reg;
  logic pllSel_reg;
  logic pllRun_reg;
  logic mainSel_reg;
  logic hsSrc_reg;
  logic hsSrcLocked_reg;
  logic extClk_reg;
  logic xtStop_reg;
  logic [2:0] stlSel_reg;
  logic [2:0] pre_reg;
  scc_state_t state_reg;
  logic hsStable;
  logic hsOut;
  logic pllReady;
  logic pllStable;
  logic settleDone;
  logic [4:0] settleStat;
  logic onHsOsc;
  logic stopped;

  // AXI write channel holding
  logic awHeld_reg;
  logic wHeld_reg;
  logic [7:0] awAddr_reg;
  logic [7:0] wData_reg;
  logic wLane0_reg;
  logic doWrite;

  assign s_axi_awready = ~awHeld_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld_reg & ~s_axi_bvalid;
  assign doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_OPC) || (a == OFS_MCS) || (a == OFS_XOC) || (a == OFS_STLST)
      || (a == OFS_STLSEL) || (a == OFS_PRE) || (a == OFS_STAT);
  endfunction

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 8'h00;
      wLane0_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata[7:0];
        wLane0_reg <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awAddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // software-visible control bits
  logic wrEn;
  assign wrEn = doWrite & wLane0_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hsStop_reg <= 1'b0;
      lsStop_reg <= 1'b0;
      pllSel_reg <= 1'b0;
      pllRun_reg <= 1'b0;
    end else if (wrEn && awAddr_reg == OFS_OPC) begin
      pllSel_reg <= wData_reg[B_PLL_SEL];
      pllRun_reg <= wData_reg[B_PLL_RUN];
      lsStop_reg <= wData_reg[B_LS_STOP];
      // refuse to stop the oscillator that feeds the CPU
      if (!(wData_reg[B_HS_STOP] && onHsOsc)) begin
        hsStop_reg <= wData_reg[B_HS_STOP];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mainSel_reg <= 1'b0;
      hsSrc_reg <= 1'b0;
      hsSrcLocked_reg <= 1'b0;
    end else if (wrEn && awAddr_reg == OFS_MCS) begin
      mainSel_reg <= wData_reg[B_MAIN_SEL];
      // source select takes one write only after reset
      if (!hsSrcLocked_reg) begin
        hsSrc_reg <= wData_reg[B_HS_SRC];
        hsSrcLocked_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xtStop_reg <= RST_XOC[B_XT_STOP];
      extClk_reg <= RST_XOC[B_EXT_CLK];
      ampHighGain <= RST_XOC[B_AMP_HI];
      stlSel_reg <= RST_STLSEL;
      pre_reg <= RST_PRE;
    end else if (wrEn) begin
      if (awAddr_reg == OFS_XOC) begin
        ampHighGain <= wData_reg[B_AMP_HI];
        // mode bits frozen while the crystal runs
        if (xtStop_reg) begin
          extClk_reg <= wData_reg[B_EXT_CLK];
        end
        // crystal may stop only when it is not the current main source, even if it feeds the PLL
        if (!(wData_reg[B_XT_STOP] && ck.srcCur == SRC_XTAL)) begin
          xtStop_reg <= wData_reg[B_XT_STOP];
        end
      end
      if (awAddr_reg == OFS_STLSEL) begin
        stlSel_reg <= wData_reg[2:0];
      end
      if (awAddr_reg == OFS_PRE) begin
        pre_reg <= wData_reg[2:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // power-up, stop and wake sequencing
  logic [15:0] pwrCnt_reg;
  logic pwrDone;
  assign pwrDone = (pwrCnt_reg >= 16'(PWR_STAB_CYC));
  assign stopped = (state_reg == ST_STOP);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwrCnt_reg <= 16'h0000;
      state_reg <= ST_PWR;
    end else begin
      case (state_reg)
        ST_PWR: begin
          // supply stabilisation wait on a fast rise only
          // reset values of the synchroniser must not be taken for a slow rise
          if (optsValid && (!fastRise || pwrDone)) begin
            state_reg <= ST_RUN;
          end else if (optsValid) begin
            pwrCnt_reg <= pwrCnt_reg + 16'h0001;
          end
        end
        ST_RUN: begin
          if (stopReq) begin
            state_reg <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (wakeReq) begin
            state_reg <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          // hardware settle wait only when the CPU runs on the crystal
          if (ck.srcCur != SRC_XTAL || settleDone) begin
            state_reg <= ST_RUN;
          end
        end
        default: state_reg <= ST_PWR;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // internal high-speed oscillator
  logic [15:0] hsCnt_reg;
  logic [2:0] hsDiv_reg;
  logic hsTick_reg;
  logic hsEn;

  // runs once the power wait ends, with no software action
  assign hsEn = ~hsStop_reg & ~stopped & (state_reg != ST_PWR);
  assign hsOut = (hsCnt_reg >= 16'(HS_START_CYC));
  assign hsStable = (hsCnt_reg >= 16'(HS_ACC_CYC));
  assign onHsOsc = (ck.srcCur == SRC_HSOSC) || (ck.srcCur == SRC_PLL && !hsSrc_reg);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hsCnt_reg <= 16'h0000;
      hsDiv_reg <= 3'h0;
      hsTick_reg <= 1'b0;
    end else if (!hsEn) begin
      hsCnt_reg <= 16'h0000;
      hsDiv_reg <= 3'h0;
      hsTick_reg <= 1'b0;
    end else begin
      if (!hsStable) begin
        hsCnt_reg <= hsCnt_reg + 16'h0001;
      end
      // rate by option; 8 MHz is approximated on a 20 MHz base
      hsTick_reg <= 1'b0;
      if (hsDiv_reg >= 3'((hs8m ? HS_DIV_8M : HS_DIV_4M) - 1)) begin
        hsDiv_reg <= 3'h0;
        hsTick_reg <= hsOut;
      end else begin
        hsDiv_reg <= hsDiv_reg + 3'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // crystal / external clock and settle counter
  logic [16:0] stlCnt_reg;
  logic [16:0] stlLim;
  assign xtalRun = ~xtStop_reg & ~stopped;
  assign stlLim = settleLimit(stlSel_reg);
  // external clock input counts as settled at once
  assign settleDone = extClk_reg | (stlCnt_reg >= stlLim);
  assign settleStat = extClk_reg ? 5'h1F :
    {stlCnt_reg >= settleLimit(3'h1), stlCnt_reg >= settleLimit(3'h2), stlCnt_reg >= settleLimit(3'h3),
     stlCnt_reg >= settleLimit(3'h4), stlCnt_reg >= settleLimit(3'h5)};

  // count saturates at the selected limit so status never passes it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stlCnt_reg <= 17'h00000;
    end else if (!xtalRun) begin
      stlCnt_reg <= 17'h00000;
    end else if (x1Rise && stlCnt_reg < stlLim) begin
      stlCnt_reg <= stlCnt_reg + 17'h00001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // PLL run timing
  logic [11:0] pllCnt_reg;
  assign pllRunOut = pllRun_reg & ~stopped;
  // output unusable during the internal wait
  assign pllReady = (pllCnt_reg >= 12'(PLL_INT_CYC));
  assign pllStable = (pllCnt_reg >= 12'(PLL_STAB_CYC));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pllCnt_reg <= 12'h000;
    end else if (!pllRunOut) begin
      pllCnt_reg <= 12'h000;
    end else if (!pllStable) begin
      pllCnt_reg <= pllCnt_reg + 12'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // low-speed oscillator
  logic [9:0] lsDiv_reg;
  // stop bit honoured only when the option allows
  assign lsOscRun = ~(lsStoppable & lsStop_reg);

  // low-speed ticks reach watchdog and timer only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lsDiv_reg <= 10'h000;
      wdtClkEn <= 1'b0;
      timerClkEn <= 1'b0;
    end else begin
      wdtClkEn <= 1'b0;
      timerClkEn <= 1'b0;
      if (!lsOscRun) begin
        lsDiv_reg <= 10'h000;
      end else if (lsDiv_reg >= 10'(LS_DIV - 1)) begin
        lsDiv_reg <= 10'h000;
        wdtClkEn <= wdtEn;
        timerClkEn <= 1'b1;
      end else begin
        lsDiv_reg <= lsDiv_reg + 10'h001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // main clock source and prescaler
  assign hsOscRun = hsEn;
  assign ck.hsTick = hsTick_reg;
  assign ck.xtTick = x1Rise & xtalRun;
  assign ck.plTick = pllReady;
  assign ck.ratio = pre_reg;
  // PLL path offered only once its output is usable
  assign ck.srcReq = (pllSel_reg && pllReady) ? SRC_PLL :
    (hsSrc_reg && mainSel_reg) ? SRC_XTAL : SRC_HSOSC;

  scc_prescaler u_presc (
    .clk(clk),
    .rst_b(rst_b),
    .ck(ck)
  );

  // CPU starts once the internal oscillator outputs
  assign cpuRun = (state_reg == ST_RUN) & (ck.srcCur != SRC_HSOSC || hsOut);
  assign cpuClkEn = ck.cpuEn & cpuRun;

  //////////////////////////////////////////////////////////////////////////
  // read channel
  function automatic logic [7:0] readMux(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      OFS_OPC: begin
        v[B_HS_STOP] = hsStop_reg;
        v[B_LS_STOP] = lsStop_reg;
        v[B_PLL_SEL] = pllSel_reg;
        v[B_PLL_RUN] = pllRun_reg;
        v[B_HS_STABLE] = hsStable;
      end
      OFS_MCS: begin
        v[B_MAIN_SEL] = mainSel_reg;
        v[B_MAIN_STAT] = (ck.srcCur == SRC_XTAL);
        v[B_HS_SRC] = hsSrc_reg;
      end
      OFS_XOC: begin
        v[B_AMP_HI] = ampHighGain;
        v[B_EXT_CLK] = extClk_reg;
        v[B_XT_STOP] = xtStop_reg;
      end
      OFS_STLST: v[4:0] = settleStat;
      OFS_STLSEL: v[2:0] = stlSel_reg;
      OFS_PRE: v[2:0] = pre_reg;
      OFS_STAT: begin
        v[B_CPU_RUN] = cpuRun;
        v[B_PLL_RDY] = pllReady;
        v[B_PLL_STBL] = pllStable;
        v[B_STOPPED] = stopped;
        v[B_HS_8M] = hs8m;
        v[B_LS_RUN] = lsOscRun;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, readMux(s_axi_araddr)};
      s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // scc_clock_gen
`default_nettype wire

//--- logic/scc_pkg.sv
package scc_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_MHZ = 20;

  // register byte offsets
  localparam logic [7:0] OFS_OPC = 8'h00;
  localparam logic [7:0] OFS_MCS = 8'h04;
  localparam logic [7:0] OFS_XOC = 8'h08;
  localparam logic [7:0] OFS_STLST = 8'h0C;
  localparam logic [7:0] OFS_STLSEL = 8'h10;
  localparam logic [7:0] OFS_PRE = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;

  // osc_pll_control_reg fields
  localparam int B_HS_STOP = 0;
  localparam int B_LS_STOP = 1;
  localparam int B_PLL_SEL = 3;
  localparam int B_PLL_RUN = 4;
  localparam int B_HS_STABLE = 7;
  // main clock select fields
  localparam int B_MAIN_SEL = 0;
  localparam int B_MAIN_STAT = 1;
  localparam int B_HS_SRC = 2;
  // crystal oscillator control fields
  localparam int B_AMP_HI = 0;
  localparam int B_EXT_CLK = 1;
  localparam int B_XT_STOP = 7;
  // status fields
  localparam int B_CPU_RUN = 0;
  localparam int B_PLL_RDY = 1;
  localparam int B_PLL_STBL = 2;
  localparam int B_STOPPED = 3;
  localparam int B_HS_8M = 4;
  localparam int B_LS_RUN = 5;

  localparam logic [7:0] RST_XOC = 8'h80;
  localparam logic [2:0] RST_STLSEL = 3'h5;
  localparam logic [2:0] RST_PRE = 3'h1;
  localparam logic [2:0] PRE_MAX = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // times in ns, then the low-speed rate in Hz and the oscillator dividers
  localparam int PLL_INT_WAIT_NS = 10_000;
  localparam int PLL_STAB_NS = 90_000;
  localparam int PWR_STAB_NS = 930_000;
  localparam int HS_START_NS = 2_000;
  localparam int HS_ACC_NS = 20_000;
  localparam int LS_HZ = 30_000;
  localparam int HS_DIV_4M = 5;
  localparam int HS_DIV_8M = 2;

  typedef enum logic [1:0] {SRC_HSOSC, SRC_XTAL, SRC_PLL} scc_src_t;
  typedef enum logic [1:0] {ST_PWR, ST_RUN, ST_STOP, ST_WAKE} scc_state_t;

  // least time, rounded up, never below one cycle
  function automatic int cyclesUp(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  // crystal edges needed for a settle-select code
  function automatic logic [16:0] settleLimit(input logic [2:0] sel);
    case (sel)
      3'h1: settleLimit = 17'h00800;
      3'h2: settleLimit = 17'h02000;
      3'h3: settleLimit = 17'h04000;
      3'h4: settleLimit = 17'h08000;
      default: settleLimit = 17'h10000;
    endcase
  endfunction
endpackage

//--- logic/scc_clk_if.sv
`timescale 1ns/10ps
`default_nettype none
interface scc_clk_if;
  import scc_pkg::*;
  logic hsTick;
  logic xtTick;
  logic plTick;
  scc_src_t srcReq;
  logic [2:0] ratio;
  logic cpuEn;
  scc_src_t srcCur;
  modport gen (output hsTick, xtTick, plTick, srcReq, ratio, input cpuEn, srcCur);
  modport presc (input hsTick, xtTick, plTick, srcReq, ratio, output cpuEn, srcCur);
endinterface
`default_nettype wire

//--- logic/scc_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module scc_prescaler
  import scc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  scc_clk_if.presc ck
);
  logic [3:0] cnt_reg;
  logic [2:0] ratioCur_reg;
  logic tick;
  logic [3:0] lim;

  always_comb begin
    case (ck.srcCur)
      SRC_XTAL: tick = ck.xtTick;
      SRC_PLL: tick = ck.plTick;
      default: tick = ck.hsTick;
    endcase
    lim = 4'((5'h1 << ratioCur_reg) - 5'h1);
  end

  // source and ratio change only at a period boundary, so no phase is cut short
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 4'h0;
      ratioCur_reg <= RST_PRE;
      ck.srcCur <= SRC_HSOSC;
      ck.cpuEn <= 1'b0;
    end else begin
      ck.cpuEn <= 1'b0;
      if (tick) begin
        if (cnt_reg >= lim) begin
          cnt_reg <= 4'h0;
          ck.cpuEn <= 1'b1;
          ck.srcCur <= ck.srcReq;
          ratioCur_reg <= (ck.ratio > PRE_MAX) ? PRE_MAX : ck.ratio;
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end
    end
  end
endmodule // scc_prescaler
`default_nettype wire

//--- test/scc_xtal_model.sv
`timescale 1ns/10ps
`default_nettype none
module scc_xtal_model (
  input wire logic enable,
  output logic clkOut
);
  // fixed 4 MHz reference
  // a stopped resonator leaves the pin low, not at its last level
  initial clkOut = 1'b0;
  always begin
    #125;
    clkOut = enable ? ~clkOut : 1'b0;
  end
endmodule // scc_xtal_model
`default_nettype wire

//--- test/scc_clock_gen_sva.sv
`timescale 1ns/10ps
`default_nettype none
module scc_clock_gen_sva
  import scc_pkg::*;
#(
  parameter int PWR_STAB_CYC = 20
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic supplyFastRise,
  input wire logic optLsStoppable,
  input wire logic optWdtEnable,
  input wire logic stopReq,
  input wire logic hsOscRun,
  input wire logic xtalRun,
  input wire logic lsOscRun,
  input wire logic pllRunOut,
  input wire logic cpuRun,
  input wire logic wdtClkEn
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // cpu needs the power wait and then the oscillator start-up
  localparam int HS_LAT = cyclesUp(HS_START_NS);
  logic [15:0] upCnt_reg;
  // saturates so a long run never wraps into the power window
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) upCnt_reg <= 16'h0000;
    else if (upCnt_reg != 16'hFFFF) upCnt_reg <= upCnt_reg + 16'h0001;
  end
  sequence stopTaken;
    stopReq && cpuRun;
  endsequence
  sequence clocksHalted;
    !hsOscRun && !xtalRun && !pllRunOut;
  endsequence
  ////////////////////////////////
  pll_off_a: assert property ($rose(rst_b) |-> !pllRunOut) else $error("pll on after reset");
  hs_start_a: assert property ($rose(rst_b) |-> ##[0:60] hsOscRun) else $error("hs osc idle");
  ls_start_a: assert property ($rose(rst_b) |-> lsOscRun) else $error("ls osc idle");
  ls_locked_a: assert property (!optLsStoppable [*5] |-> lsOscRun) else $error("ls osc stopped");
  wdt_off_a: assert property (!optWdtEnable [*5] |-> !wdtClkEn) else $error("wdt tick");
  cpu_up_a: assert property ($rose(rst_b) && !supplyFastRise |-> ##[1:60] cpuRun) else $error("cpu late");
  pwr_wait_a: assert property (supplyFastRise && upCnt_reg < PWR_STAB_CYC + HS_LAT |-> !cpuRun)
    else $error("cpu early");
  stop_halt_a: assert property (stopTaken |-> ##[1:4] clocksHalted) else $error("clocks run in stop");
  hs_needed_a: assert property (cpuRun && !xtalRun |-> hsOscRun) else $error("cpu clock lost");
endmodule // scc_clock_gen_sva
bind scc_clock_gen scc_clock_gen_sva #(.PWR_STAB_CYC(PWR_STAB_CYC)) sva (.clk, .rst_b, .supplyFastRise,
  .optLsStoppable, .optWdtEnable, .stopReq, .hsOscRun, .xtalRun, .lsOscRun, .pllRunOut, .cpuRun, .wdtClkEn);
`default_nettype wire

//--- test/system_clock_pll_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module system_clock_pll_control_bench;
  import scc_pkg::*;
  logic clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic optHs8M, optLsStoppable, optWdtEnable, supplyFastRise, x1ClkPin, stopReq, wakeReq;
  logic hsOscRun, xtalRun, lsOscRun, pllRunOut, cpuClkEn, cpuRun, wdtClkEn, ampHighGain, timerClkEn;
  logic [34:0] expQ[$];
  int failures, comparisons, seed, r;
  scc_clock_gen #(.PWR_STAB_CYC(20)) dut (.clk, .rst_b, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .optHs8M, .optLsStoppable,
    .optWdtEnable, .supplyFastRise, .x1ClkPin, .stopReq, .wakeReq, .hsOscRun, .xtalRun, .lsOscRun,
    .pllRunOut, .ampHighGain(ampHighGain), .cpuClkEn, .cpuRun, .wdtClkEn, .timerClkEn(timerClkEn));
  scc_xtal_model xtal (.enable(xtalRun), .clkOut(x1ClkPin));
  always #25 clk = ~clk;
  ////////////////////////////////
  task automatic check(input logic [34:0] seen, input logic [34:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // responses are matched in order, one bus transfer each
  always @(posedge clk) begin
    if (bvalid && bready) check({1'b1, bresp, 32'h0}, expQ.pop_front());
    if (rvalid && rready) check({1'b0, rresp, rdata}, expQ.pop_front());
  end
  task automatic axiWrite(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rsp);
    expQ.push_back({1'b1, rsp, 32'h0});
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
  endtask
  task automatic axiRead(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rsp);
    expQ.push_back({1'b0, rsp, 24'h0, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
  endtask
  // measures pulse spacing after two pulses, so a pending ratio has landed
  task automatic period(input logic wdt, input int e);
    int n;
    n = 0;
    repeat (2) @(posedge clk iff (wdt ? wdtClkEn : cpuClkEn));
    do begin
      @(posedge clk);
      n++;
    end while (!(wdt ? wdtClkEn : cpuClkEn));
    check(35'(n), 35'(e));
  endtask
  initial begin
    #2_000_000;
    failures++;
    conclude();
  end
  ////////////////////////////////
  initial begin
    seed = 17411;
    {clk, rst_b, awvalid, wvalid, bready, arvalid, rready, stopReq, wakeReq} = '0;
    {awaddr, araddr, wdata, optHs8M, optLsStoppable, optWdtEnable} = '0;
    supplyFastRise = 1'b1;
    failures = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    // past the supply wait, still inside the oscillator start-up that follows it
    repeat (50) @(posedge clk);
    check(35'(cpuRun), 35'h0);
    @(posedge clk iff cpuRun);
    supplyFastRise <= 1'b0;
    rst_b <= 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk iff cpuRun);
    $display("power test done");
    repeat (450) @(posedge clk);
    axiRead(OFS_OPC, 8'h80, RESP_OKAY);
    axiRead(OFS_XOC, 8'h80, RESP_OKAY);
    axiRead(OFS_STLSEL, 8'h05, RESP_OKAY);
    axiRead(OFS_PRE, 8'h01, RESP_OKAY);
    axiRead(OFS_STAT, 8'h21, RESP_OKAY);
    axiRead(8'h1C, 8'h00, RESP_SLVERR);
    axiWrite(8'h1C, 8'hFF, RESP_SLVERR);
    $display("register test done");
    optWdtEnable <= 1'b1;
    period(1'b1, 666);
    check(35'(timerClkEn), 35'h1);
    axiWrite(OFS_OPC, 8'h02, RESP_OKAY);
    check(35'(lsOscRun), 35'h1);
    optLsStoppable <= 1'b1;
    repeat (4) @(posedge clk);
    axiWrite(OFS_OPC, 8'h02, RESP_OKAY);
    check(35'(lsOscRun), 35'h0);
    axiWrite(OFS_OPC, 8'h01, RESP_OKAY);
    check(35'(hsOscRun), 35'h1);
    $display("oscillator test done");
    axiWrite(OFS_OPC, 8'h10, RESP_OKAY);
    check(35'(pllRunOut), 35'h1);
    repeat (100) @(posedge clk);
    axiRead(OFS_STAT, 8'h21, RESP_OKAY);
    repeat (150) @(posedge clk);
    axiRead(OFS_STAT, 8'h23, RESP_OKAY);
    repeat (1700) @(posedge clk);
    axiRead(OFS_STAT, 8'h27, RESP_OKAY);
    axiWrite(OFS_OPC, 8'h18, RESP_OKAY);
    axiRead(OFS_OPC, 8'h98, RESP_OKAY);
    // high-speed source left on the internal oscillator in PLL mode
    axiRead(OFS_MCS, 8'h00, RESP_OKAY);
    axiWrite(OFS_OPC, 8'h10, RESP_OKAY);
    axiWrite(OFS_OPC, 8'h00, RESP_OKAY);
    check(35'(pllRunOut), 35'h0);
    $display("pll test done");
    for (int i = 0; i < 6; i++) begin
      r = (i < 5) ? i : $unsigned($random(seed)) % 5;
      if (i == 5) optHs8M <= 1'b1;
      axiWrite(OFS_PRE, 8'(r), RESP_OKAY);
      axiRead(OFS_PRE, 8'(r), RESP_OKAY);
      period(1'b0, (i == 5 ? 2 : 5) << r);
    end
    axiRead(OFS_STAT, 8'h31, RESP_OKAY);
    $display("prescaler test done");
    axiWrite(OFS_STLSEL, 8'h01, RESP_OKAY);
    axiWrite(OFS_XOC, 8'h01, RESP_OKAY);
    check(35'(xtalRun), 35'h1);
    check(35'(ampHighGain), 35'h1);
    repeat (5000) @(posedge clk);
    axiRead(OFS_STLST, 8'h00, RESP_OKAY);
    repeat (6000) @(posedge clk);
    axiRead(OFS_STLST, 8'h10, RESP_OKAY);
    stopReq <= 1'b1;
    @(posedge clk);
    stopReq <= 1'b0;
    repeat (5) @(posedge clk);
    check({32'h0, hsOscRun, xtalRun, cpuRun}, 35'h0);
    wakeReq <= 1'b1;
    @(posedge clk);
    wakeReq <= 1'b0;
    @(posedge clk iff cpuRun);
    check(35'(pllRunOut), 35'h0);
    $display("stop test done");
    conclude();
  end
endmodule // system_clock_pll_control_bench
`default_nettype wire
